/* File: design/dtc_pkg.sv */
/*
  dtc_pkg: shared constants and carrier types for the disk task
  command/status block.
  assumes: included before every design file of the block.
*/
// How it works
// - busy set on command, cleared at end
// - bits 6,5 mirror ready, fault; abort
// - bit 3 mirrors buffer transfer request
// - bit 2 flags corrected data field
// - bit 1 set while command executes
// - bit 0 flags unrecoverable error
// - drive bits frozen at end, released on read; seek bit held after abort
// - fault latched after 8 write clocks
// - status read drops host interrupt
// - command write while not active sets busy, active, clears irq
// - opcodes decode from upper bits
// - step-rate field picks step time
// - step pulse width slow/fast rate
// - odd rate 2 index, even 10 index
// - interrupt timing option
// - multi-sector and retry options
// - long mode extends 4 or 7 bytes
// - auto-scan disable skips scan and seeks
// - sync length fixed or programmable
// - gap and pad fill selection
// - check length and correction span
// - head-field split 2/3 or 1/4
// - busy hides bits; active returns status
`default_nettype none
package dtc_pkg;
  localparam logic [2:0] DTC_CMD_OFS   = 3'h7; // command/status
  localparam int         DTC_BSY_BIT   = 7;
  localparam int         DTC_RDY_BIT   = 6;
  localparam int         DTC_WF_BIT    = 5;
  localparam int         DTC_SC_BIT    = 4;
  localparam int         DTC_DRQ_BIT   = 3;
  localparam int         DTC_DWC_BIT   = 2;
  localparam int         DTC_CIP_BIT   = 1;
  localparam int         DTC_ERR_BIT   = 0;
  localparam int         DTC_FILT_WC   = 8;   // write clocks of fault
  localparam int         DTC_IDX_ODD   = 2;
  localparam int         DTC_IDX_EVEN  = 10;
  localparam int         DTC_SYNC_X2   = 29;  // 14.5 bytes, halves
  localparam logic [7:0] DTC_GAP_4E    = 8'h4E;
  localparam logic [7:0] DTC_GAP_33    = 8'h33;
  localparam logic [7:0] DTC_PAD_AA    = 8'hAA;
  localparam logic [7:0] DTC_FILL_00   = 8'h00;
  localparam logic [7:0] DTC_FILL_FF   = 8'hFF;
  localparam int         DTC_WC_KHZ    = 10000; // nominal write clock
  // step times in tenths of a microsecond, codes 0..15
  localparam int DTC_STEP_US10 [16] = '{172, 2500, 5000, 7500, 10000,
    13000, 15000, 18000, 20000, 23000, 25000, 28000, 30000, 33000, 16,
    80};
  localparam int DTC_PW_SLOW_NS = 4000;
  localparam int DTC_PW_FAST_NS = 800;

  typedef enum {DTC_OP_NONE, DTC_OP_RESTORE, DTC_OP_SEEK, DTC_OP_READ,
    DTC_OP_RDNEXT, DTC_OP_WRITE, DTC_OP_SCAN, DTC_OP_FORMAT,
    DTC_OP_CORR, DTC_OP_SETP, DTC_OP_AUXP} dtc_op_e;

  // decoded command with its option flags
  typedef struct packed {
    logic [3:0] step_rate_field;
    logic       irq_at_end;   // I
    logic       multi;        // M
    logic       no_retry;     // T
    logic       long_mode;    // L
    logic       no_autoscan;  // N
    logic       sync_prog;    // B
    logic       pad_aa;       // A
    logic       gap_alt;      // F
    logic       ecc7;         // E
    logic       span_wide;    // S
    logic       head4;        // H
    logic       nrz;          // Z
  } dtc_opt_s;

  // setup derived from options, to the data path
  typedef struct packed {
    logic [7:0] gap_fill;
    logic [7:0] pad_fill;
    logic [2:0] ext_bytes;
    logic [4:0] corr_span;
    logic [5:0] sync_len_x2;
    logic [1:0] drive_sel;
    logic [3:0] head_sel;
    logic       one_sector;
    logic       retries_on;
    logic       skip_scan;
    logic       check_off;
  } dtc_setup_s;
endpackage
`default_nettype wire

/* File: design/dtc_filter.sv */
/*
  dtc_filter: counts consecutive enabled samples of a condition and
  reports it once it has held for a fixed number.
  assumes: cond already synchronous to clk_sys.
*/
`default_nettype none
module dtc_filter
  import dtc_pkg::*;
#(
  parameter int LEN = DTC_FILT_WC
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // sample
  input  wire logic tick,
  input  wire logic cond,
  // result
  output logic      held
);
  logic [4:0] cnt;       // run length
  logic [4:0] next_cnt;

  // restart on any break in the condition
  always_comb begin
    next_cnt = cnt;
    if (!cond) begin
      next_cnt = 5'h0;
    end else if (tick && cnt < 5'(LEN)) begin
      next_cnt = cnt + 5'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 5'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign held = (cnt >= 5'(LEN));
endmodule
`default_nettype wire

/* File: design/dtc_stepper.sv */
/*
  dtc_stepper: step timer. Gives a step pulse of slow or fast width
  and spaces steps by the selected step time, counted in write-clock
  ticks.
  assumes: wc_tick is one cycle per write clock period.
*/
`default_nettype none
module dtc_stepper
  import dtc_pkg::*;
#(
  parameter int WC_KHZ = DTC_WC_KHZ
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // control
  input  wire logic       wc_tick,
  input  wire logic       start,
  input  wire logic [3:0] step_rate_field,
  // outputs
  output logic            step_pulse,
  output logic            step_busy
);
  localparam int PW_SLOW = DTC_PW_SLOW_NS * WC_KHZ / 1000000;
  localparam int PW_FAST = (DTC_PW_FAST_NS * WC_KHZ + 999999) / 1000000;
  logic [19:0] per_cnt, next_per_cnt;   // step period left
  logic [7:0]  pw_cnt, next_pw_cnt;     // pulse left
  logic [19:0] period;
  logic        fast;

  always_comb begin
    period = 20'(DTC_STEP_US10[step_rate_field] * (WC_KHZ / 1000) / 10);
    if (period == 20'h0) begin
      period = 20'h1;
    end
  end
  // fast codes get the narrow pulse
  assign fast = (step_rate_field == 4'h0) || (step_rate_field >= 4'hE);

  always_comb begin
    next_per_cnt = per_cnt;
    next_pw_cnt  = pw_cnt;
    if (start && per_cnt == 20'h0) begin
      next_per_cnt = period;
      next_pw_cnt  = fast ? 8'(PW_FAST) : 8'(PW_SLOW);
    end else if (wc_tick) begin
      if (per_cnt != 20'h0) next_per_cnt = per_cnt - 20'h1;
      if (pw_cnt != 8'h0)   next_pw_cnt  = pw_cnt - 8'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt    <= 20'h0;
      pw_cnt     <= 8'h0;
      step_pulse <= 1'b0;
    end else begin
      per_cnt    <= next_per_cnt;
      pw_cnt     <= next_pw_cnt;
      step_pulse <= (next_pw_cnt != 8'h0);
    end
  end
  assign step_busy = (per_cnt != 20'h0);
endmodule
`default_nettype wire

/* File: design/dtc_top.sv */
/*
  dtc_top: host command and status logic. Takes command writes,
  decodes opcode and options, keeps status bits, drives the host
  interrupt and the step timer.
  assumes: host strobes are synchronous one-cycle pulses; drive pins
  and the write clock are asynchronous and synchronised here.
*/
`default_nettype none
module dtc_top
  import dtc_pkg::*;
#(
  parameter int WC_KHZ = DTC_WC_KHZ
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // host register port
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] other_rdata,
  output logic      [7:0] reg_rdata,
  output logic            host_interrupt,
  // drive and buffer pins
  input  wire logic       drive_ready_input,
  input  wire logic       write_fault_input,
  input  wire logic       seek_done_input,
  input  wire logic       buffer_transfer_request,
  input  wire logic       write_clock_input,
  input  wire logic       index_pulse,
  // command engine
  input  wire logic       cmd_done,
  input  wire logic       sector_ready,
  input  wire logic       buffer_read_done,
  input  wire logic       corrected,
  input  wire logic       hard_error,
  input  wire logic       step_req,
  input  wire logic       rll_mode,
  input  wire logic [5:0] sync_reg,
  input  wire logic [7:0] drive_head_register,
  output logic            cmd_start,
  output logic            cmd_abort,
  output dtc_op_e         cmd_op,
  output dtc_opt_s        cmd_opt,
  output dtc_setup_s      setup,
  output logic            seek_level_sense,
  output logic            step_pulse
);
  // two-flop synchronisers: ready, fault, seek, drq, wc, index
  logic [5:0] s1, s2, s3;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 6'h0;
      s2 <= 6'h0;
      s3 <= 6'h0;
    end else begin
      s1 <= {index_pulse, write_clock_input, buffer_transfer_request,
             seek_done_input, write_fault_input, drive_ready_input};
      s2 <= s1;
      s3 <= s2;
    end
  end
  logic rdy, wf, sc, transfer_request_flag, wc_tick, idx_rise;
  assign rdy      = s2[0];
  assign wf       = s2[1];
  assign sc       = s2[2];
  assign transfer_request_flag      = s2[3];
  assign wc_tick  = s2[4] & ~s3[4];   // write clock rising edge
  assign idx_rise = s2[5] & ~s3[5];

  logic nr_held, wf_held;
  dtc_filter #(.LEN(DTC_FILT_WC)) u_nr (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(wc_tick), .cond(!rdy),
    .held(nr_held));
  dtc_filter #(.LEN(DTC_FILT_WC)) u_wf (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(wc_tick), .cond(wf),
    .held(wf_held));

  // decode of a written command
  logic cmd_wr, st_rd, oth_rd;
  assign cmd_wr = reg_wr && reg_addr == DTC_CMD_OFS;
  assign st_rd  = reg_rd && reg_addr == DTC_CMD_OFS;
  assign oth_rd = reg_rd && reg_addr != DTC_CMD_OFS;
  dtc_op_e  dec_op;
  dtc_opt_s dec_opt;
  logic [7:0] c;
  assign c = reg_wdata;
  always_comb begin
    dec_op = DTC_OP_NONE;
    if (c[7:4] == 4'b0001) dec_op = DTC_OP_RESTORE;
    else if (c[7:4] == 4'b0111) dec_op = DTC_OP_SEEK;
    else if (c[6:3] == 4'b0101) dec_op = DTC_OP_READ;
    else if (c[6:3] == 4'b1101) dec_op = DTC_OP_RDNEXT;
    else if (c[6:3] == 4'b0110) dec_op = DTC_OP_WRITE;
    else if (c[7:3] == 5'b01000) dec_op = DTC_OP_SCAN;
    else if (c[6:3] == 4'b1010) dec_op = DTC_OP_FORMAT;
    else if (c[7:3] == 5'b00001) dec_op = DTC_OP_CORR;
    else if (c[7:3] == 5'b10001) dec_op = DTC_OP_AUXP;
    else if (c[6:3] == 4'b0000) dec_op = DTC_OP_SETP;
  end
  // option bits; step rate survives non-step commands
  always_comb begin
    dec_opt = cmd_opt;
    dec_opt.no_autoscan = c[7];
    dec_opt.multi     = c[2];
    dec_opt.long_mode = c[1];
    dec_opt.no_retry  = c[0];
    dec_opt.irq_at_end = c[3];
    if (dec_op == DTC_OP_RESTORE || dec_op == DTC_OP_SEEK) begin
      dec_opt.step_rate_field = c[3:0];
    end
    if (dec_op == DTC_OP_FORMAT) begin
      dec_opt.pad_aa  = c[2];
      dec_opt.sync_prog = c[1];
      dec_opt.gap_alt = c[0];
    end
    if (dec_op == DTC_OP_SETP) begin
      dec_opt.nrz       = c[7];
      dec_opt.ecc7      = c[2];
      dec_opt.head4     = c[1];
      dec_opt.span_wide = c[0];
    end
    if (dec_op == DTC_OP_RDNEXT) begin
      dec_opt.multi    = 1'b0;
      dec_opt.no_retry = 1'b1;
    end
  end

  // status and command state
  logic busy, next_busy, active, next_active, irq, next_irq;
  logic data_corrected_flag, next_dwc, err, next_err, frozen, next_frozen;
  logic aborted, next_aborted;
  logic [2:0] frz, next_frz;       // held ready, fault, seek
  logic abort_now, drq_rise, drq_d;
  assign abort_now = active && (nr_held || wf_held);
  assign drq_rise  = transfer_request_flag && !drq_d;

  always_comb begin
    next_busy = busy;
    next_active = active;
    next_irq = irq;
    next_dwc = data_corrected_flag;
    next_err = err;
    next_frozen = frozen;
    next_frz = frz;
    next_aborted = aborted;
    if (st_rd) next_frozen = 1'b0;
    if (st_rd) next_irq = 1'b0;
    if (active && sector_ready && cmd_op == DTC_OP_READ) next_busy = 1'b0;
    if (active && drq_rise && !cmd_opt.irq_at_end) next_irq = 1'b1;
    if (corrected) next_dwc = 1'b1;
    if (hard_error) next_err = 1'b1;
    // abort on lost ready or fault
    if (abort_now || (active && cmd_done)) begin
      next_busy = 1'b0;
      next_active = 1'b0;
      next_irq = 1'b1;
      next_frozen = 1'b1;
      next_frz = {!nr_held && rdy, wf_held || wf, sc};
      if (abort_now) begin
        next_err = 1'b1;
        next_aborted = 1'b1;
      end
    end
    // end-time irq only if buffer read comes with done
    if (active && cmd_done && cmd_opt.irq_at_end && !buffer_read_done) begin
      next_irq = irq;
    end
    if (cmd_wr && !active) begin
      next_busy = 1'b1;
      next_active = 1'b1;
      next_irq = 1'b0;
      next_dwc = corrected;  // a same-cycle event still sets
      next_err = hard_error;
      next_frozen = 1'b0;
      next_aborted = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      active <= 1'b0;
      irq <= 1'b0;
      data_corrected_flag <= 1'b0;
      err <= 1'b0;
      frozen <= 1'b0;
      frz <= 3'h0;
      aborted <= 1'b0;
      drq_d <= 1'b0;
    end else begin
      busy <= next_busy;
      active <= next_active;
      irq <= next_irq;
      data_corrected_flag <= next_dwc;
      err <= next_err;
      frozen <= next_frozen;
      frz <= next_frz;
      aborted <= next_aborted;
      drq_d <= transfer_request_flag;
    end
  end

  // status byte
  logic [7:0] stat;
  always_comb begin
    stat = 8'h00;
    stat[DTC_BSY_BIT] = busy;
    stat[DTC_RDY_BIT] = frozen ? frz[2] : rdy;
    stat[DTC_WF_BIT]  = frozen ? frz[1] : wf;
    stat[DTC_SC_BIT]  = (frozen || aborted) ? frz[0] : sc;
    stat[DTC_DRQ_BIT] = transfer_request_flag;
    stat[DTC_DWC_BIT] = data_corrected_flag;
    stat[DTC_CIP_BIT] = active;
    stat[DTC_ERR_BIT] = err;
    if (busy) stat = 8'h80;
  end

  logic [3:0] idx_cnt, next_idx_cnt;
  logic       lvl, next_lvl, sc_d;
  always_comb begin
    next_idx_cnt = idx_cnt;
    next_lvl = lvl;
    if (step_pulse || (sc && !sc_d)) begin
      next_idx_cnt = 4'h0;
      next_lvl = 1'b0;
    end else if (idx_rise && !lvl) begin
      next_idx_cnt = idx_cnt + 4'h1;
      if (next_idx_cnt == (cmd_opt.step_rate_field[0] ?
          4'(DTC_IDX_ODD) : 4'(DTC_IDX_EVEN))) next_lvl = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx_cnt <= 4'h0;
      lvl <= 1'b0;
      sc_d <= 1'b0;
    end else begin
      idx_cnt <= next_idx_cnt;
      lvl <= next_lvl;
      sc_d <= sc;
    end
  end

  logic stp;
  dtc_stepper #(.WC_KHZ(WC_KHZ)) u_step (
    .clk_sys(clk_sys), .rst_n(rst_n), .wc_tick(wc_tick),
    .start(step_req && active),
    .step_rate_field(cmd_opt.step_rate_field),
    .step_pulse(stp), .step_busy());

  // derived setup
  dtc_setup_s nsetup;
  always_comb begin
    nsetup.pad_fill = (cmd_opt.gap_alt && cmd_opt.sync_prog) ? DTC_FILL_00
                    : cmd_opt.pad_aa ? DTC_PAD_AA
                    : (rll_mode ? DTC_GAP_33 : DTC_FILL_00);
    nsetup.gap_fill = (cmd_opt.gap_alt && cmd_opt.sync_prog) ? DTC_FILL_00
                    : cmd_opt.pad_aa ? DTC_PAD_AA
                    : (rll_mode ? DTC_GAP_33 : DTC_GAP_4E);
    nsetup.ext_bytes = (cmd_opt.ecc7 || rll_mode) ? 3'h7 : 3'h4;
    nsetup.corr_span = (cmd_opt.ecc7 || rll_mode)
      ? (cmd_opt.span_wide ? 5'd22 : 5'd11)
      : (cmd_opt.span_wide ? 5'd11 : 5'd5);
    nsetup.sync_len_x2 = cmd_opt.sync_prog ? {sync_reg[4:0], 1'b0}
                                           : 6'(DTC_SYNC_X2);
    nsetup.drive_sel = cmd_opt.head4 ? {1'b0, drive_head_register[4]}
                                     : drive_head_register[4:3];
    nsetup.head_sel  = cmd_opt.head4 ? drive_head_register[3:0]
                                     : {1'b0, drive_head_register[2:0]};
    nsetup.one_sector = !cmd_opt.multi;
    nsetup.retries_on = !cmd_opt.no_retry;
    nsetup.skip_scan  = cmd_opt.no_autoscan;
    nsetup.check_off  = cmd_opt.long_mode;
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      host_interrupt <= 1'b0;
      cmd_start <= 1'b0;
      cmd_abort <= 1'b0;
      cmd_op <= DTC_OP_NONE;
      cmd_opt <= '0;
      setup <= '0;
      seek_level_sense <= 1'b0;
      step_pulse <= 1'b0;
    end else begin
      reg_rdata <= (st_rd || (oth_rd && active)) ? stat
                 : (oth_rd ? other_rdata : reg_rdata);
      host_interrupt <= next_irq;
      cmd_start <= cmd_wr && !active;
      cmd_abort <= abort_now;
      if (cmd_wr && !active) begin
        cmd_op <= dec_op;
        cmd_opt <= dec_opt;
      end
      setup <= nsetup;
      seek_level_sense <= next_lvl;
      step_pulse <= stp;
    end
  end

  // assertions
  AST_CMD_SETS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_wr && !active) |=> (busy && active && !host_interrupt))
    else $error("command write did not start");
  AST_RD_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_rd && !(active && (cmd_done || abort_now || drq_rise))) |=>
    !host_interrupt)
    else $error("status read left interrupt");
  AST_ABORT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (abort_now && !cmd_wr) |=> (!active && err))
    else $error("abort not taken");
  AST_FILT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (active && rdy && !wf) |=> !cmd_abort)
    else $error("abort without condition");
  AST_BUSY_HIDE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_rd && busy) |=> (reg_rdata == 8'h80))
    else $error("busy status not masked");
  AST_CIP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_rd && !busy) |=> reg_rdata[DTC_CIP_BIT] == $past(active))
    else $error("active bit wrong");
  AST_DRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_rd && !busy) |=> reg_rdata[DTC_DRQ_BIT] == $past(transfer_request_flag))
    else $error("request bit not mirrored");
  AST_ERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hard_error |=> err)
    else $error("error bit not set");
endmodule
`default_nettype wire

/* File: tb/dtc_host_model.sv */
/*
  dtc_host_model: host side of the register port, byte writes and
  reads as one-cycle strobes launched at the falling edge.
  assumes: tasks are called from the bench, reg_rdata is registered.
*/
`default_nettype none
module dtc_host_model (
  // clock
  input  wire logic       clk_sys,
  // register port
  input  wire logic [7:0] reg_rdata,
  output logic      [2:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idle at time zero
  initial begin
    reg_addr  = 3'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_wdata = ~d; // stale data must not look valid
  endtask

  // read data lands one cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd   = 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_disk_task_command_status.sv */
/*
  test_disk_task_command_status: self-checking bench of dtc_top.
  assumes: dtc_pkg, the design and the host model compiled first.
*/
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
  err_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
  end end
module test_disk_task_command_status
  import dtc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  // clock, reset, register port
  logic       clk_sys, rst_n, wclk;
  logic [2:0] reg_addr;
  logic       reg_wr, reg_rd, host_interrupt;
  logic [7:0] reg_wdata, other_rdata, reg_rdata, st, d;
  // drive pins and engine strobes
  logic       drive_ready_input, write_fault_input, buffer_req;
  logic       rll_mode, cmd_start, cmd_abort, idx, step_rq, seek_lvl;
  logic       step_out, ab_seen = 1'b0;
  dtc_setup_s setup_o;  // derived setup from the design
  int         n;        // step pulse width in cycles
  logic [4:0] eng; // done, sector, buf read, corrected, hard
  logic [5:0] sync_reg;
  logic [7:0] dh_reg;
  dtc_op_e    cmd_op;
  dtc_opt_s   cmd_opt;
  int         err_count = 0;
  int         checked = 0;
  logic [31:0] lfsr = 32'h5cb6_cc1a;
  // opcode table: base, option mask, decoded kind
  logic [7:0] op_base [10] = '{8'h10, 8'h70, 8'h28, 8'h69, 8'h30,
    8'h40, 8'h50, 8'h08, 8'h00, 8'h88};
  logic [7:0] op_mask [10] = '{8'h0F, 8'h0F, 8'h87, 8'h82, 8'h87,
    8'h01, 8'h87, 8'h01, 8'h87, 8'h07};
  dtc_op_e    op_exp [10] = '{DTC_OP_RESTORE, DTC_OP_SEEK, DTC_OP_READ,
    DTC_OP_RDNEXT, DTC_OP_WRITE, DTC_OP_SCAN, DTC_OP_FORMAT,
    DTC_OP_CORR, DTC_OP_SETP, DTC_OP_AUXP};

  // next random byte, eight shifts per call
  function automatic logic [7:0] nxt();
    repeat (8) lfsr = {lfsr[30:0], lfsr[31]^lfsr[21]^lfsr[1]^lfsr[0]};
    return lfsr[7:0];
  endfunction

  dtc_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));

  dtc_top #(.WC_KHZ(DTC_WC_KHZ)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .other_rdata(other_rdata),
    .reg_rdata(reg_rdata), .host_interrupt(host_interrupt),
    .drive_ready_input(drive_ready_input),
    .write_fault_input(write_fault_input), .seek_done_input(1'b1),
    .buffer_transfer_request(buffer_req), .write_clock_input(wclk),
    .index_pulse(idx), .cmd_done(eng[0]), .sector_ready(eng[1]),
    .buffer_read_done(eng[2]), .corrected(eng[3]),
    .hard_error(eng[4]), .step_req(step_rq), .rll_mode(rll_mode),
    .sync_reg(sync_reg), .drive_head_register(dh_reg),
    .cmd_start(cmd_start), .cmd_abort(cmd_abort), .cmd_op(cmd_op),
    .cmd_opt(cmd_opt), .setup(setup_o), .seek_level_sense(seek_lvl),
    .step_pulse(step_out));

  // system clock, then write clock at 10 MHz, free phase
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    wclk = 1'b0;
    #13;
    forever #50 wclk = ~wclk;
  end

  // sticky record of any abort pulse
  always @(posedge clk_sys) begin
    if (cmd_abort === 1'b1) ab_seen <= 1'b1;
  end

  // engine strobe, one cycle wide
  task automatic pulse(input logic [4:0] m);
    @(negedge clk_sys);
    eng = m;
    @(negedge clk_sys);
    eng = 5'h00;
  endtask

  task automatic end_sim();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far beyond the roughly one thousand cycles needed
  initial begin
    #200000;
    err_count++;
    end_sim();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    eng = 5'h00;
    idx = 1'b0;
    step_rq = 1'b0;
    other_rdata = 8'h00;
    drive_ready_input = 1'b1;
    write_fault_input = 1'b0;
    buffer_req = 1'b0;
    rll_mode = 1'b0;
    sync_reg = 6'h00;
    dh_reg = 8'h00;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    // every opcode with random options
    for (int i = 0; i < 10; i++) begin
      d = op_base[i] | (nxt() & op_mask[i]);
      other_rdata = nxt() & 8'h7D; // busy and active bits clear
      st = nxt();
      {rll_mode, sync_reg} = st[6:0];
      dh_reg = nxt();
      host.wr(DTC_CMD_OFS, d);
      `CHK(cmd_start, 1'b1)
      `CHK(host_interrupt, 1'b0)
      `CHK(cmd_op, op_exp[i])
      if (i == 1) `CHK(cmd_opt.step_rate_field, d[3:0])
      if (i == 2) `CHK({cmd_opt.no_autoscan, cmd_opt.multi,
        cmd_opt.long_mode, cmd_opt.no_retry}, {d[7], d[2:0]})
      if (i == 6) `CHK({cmd_opt.pad_aa, cmd_opt.sync_prog,
        cmd_opt.gap_alt}, d[2:0])
      if (i == 8) `CHK({cmd_opt.ecc7, cmd_opt.head4,
        cmd_opt.span_wide}, d[2:0])
      // second command while active is dropped
      host.wr(DTC_CMD_OFS, 8'h70);
      @(negedge clk_sys);
      `CHK(cmd_start, 1'b0)
      host.rd(3'h3, st);
      `CHK(st, 8'h80)
      if (i == 8) `CHK(setup_o.ext_bytes,
        (d[2] || rll_mode) ? 3'h7 : 3'h4)
      if (i == 2) begin
        pulse(5'h02); // sector in buffer ends busy only
        host.rd(DTC_CMD_OFS, st);
        `CHK({st[DTC_BSY_BIT], st[DTC_CIP_BIT]}, 2'b01)
      end
      pulse(5'h05);
      host.rd(DTC_CMD_OFS, st);
      `CHK({st[DTC_BSY_BIT], st[DTC_CIP_BIT]}, 2'b00)
    end
    // corrected data, interrupt, frozen drive bits
    host.wr(DTC_CMD_OFS, 8'h7F);
    // odd rate: two index pulses switch to level sense
    repeat (2) begin
      `CHK(seek_lvl, 1'b0)
      idx = 1'b1;
      repeat (4) @(negedge clk_sys);
      idx = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    `CHK(seek_lvl, 1'b1)
    // fast rate step pulse lasts eight write clocks
    step_rq = 1'b1;
    @(negedge clk_sys);
    step_rq = 1'b0;
    n = 0;
    repeat (400) begin
      @(negedge clk_sys);
      if (step_out === 1'b1) n++;
    end
    `CHK(n > 140 && n < 161, 1'b1)
    pulse(5'h08);
    pulse(5'h05);
    @(negedge clk_sys);
    `CHK(host_interrupt, 1'b1)
    drive_ready_input = 1'b0;
    repeat (4) @(negedge clk_sys);
    host.rd(DTC_CMD_OFS, st);
    `CHK(host_interrupt, 1'b0)
    `CHK({st[DTC_RDY_BIT], st[DTC_DWC_BIT]}, 2'b11)
    host.rd(DTC_CMD_OFS, st);
    `CHK(st[DTC_RDY_BIT], 1'b0)
    drive_ready_input = 1'b1;
    buffer_req = 1'b1;
    repeat (4) @(negedge clk_sys);
    host.rd(DTC_CMD_OFS, st);
    `CHK({st[DTC_RDY_BIT], st[DTC_DRQ_BIT]}, 2'b11)
    buffer_req = 1'b0;
    // fault: short glitch ignored, long one aborts
    host.wr(DTC_CMD_OFS, 8'h70);
    write_fault_input = 1'b1;
    repeat (60) @(negedge clk_sys); // three write clocks
    write_fault_input = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK(ab_seen, 1'b0)
    write_fault_input = 1'b1;
    repeat (240) @(negedge clk_sys); // twelve write clocks
    `CHK(ab_seen, 1'b1)
    write_fault_input = 1'b0;
    pulse(5'h11);
    host.rd(DTC_CMD_OFS, st);
    `CHK(st[DTC_ERR_BIT], 1'b1)
    end_sim();
  end
endmodule
`undef CHK
`default_nettype wire
